/* payload_command_frame_sender.sv */
/*
 * Payload command frame sender: holds the command bytes of one message,
 * sends idle bits, then sync and command bytes serially, MSB first.
 * Assumes the loader writes bytes while not busy, and one clock domain.
 */
`timescale 1ns/1ps
`include "cmd_frame_consts.svh"
module payload_command_frame_sender
  import cmd_frame_pkg::*;
#(
  parameter int BIT_CYCLES = `BIT_CYCLES_DFLT
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // Payload byte loading, index 0 is message byte 3
  input wire byte_wr_t loadReq,
  output logic loadRdy,
  // Message start, lastIdx is the index N of the last byte
  input wire logic start,
  input wire logic [6:0] lastIdx,
  output logic busy,
  output logic rejectPulse_r,
  output logic donePulse_r,
  // Serial command line
  output logic txBit_r
);

  // ****************************************************************
  // State
  // ****************************************************************
  tx_state_t state_r;
  logic pend_r;
  logic [31:0] bitCnt_r;
  logic tick;
  logic [7:0] shift_r;
  logic [2:0] bitIdx_r;
  logic [6:0] byteIdx_r;
  logic [6:0] lastIdx_r;
  logic [7:0] rdData;
  logic [6:0] rdAddr;
  logic startOk;
  logic startTake;
  logic frameGo;
  logic byteEnd;
  logic [7:0] nextByte;
  logic [7:0] firstByte;
  byte_wr_t wrGated;

  // Picks the byte at a message position
  function automatic logic [7:0] byte_at(input logic [6:0] idx, input logic [7:0] ram);
    unique case (idx)
      7'h00: byte_at = `SYNC_BYTE0;
      7'h01: byte_at = `SYNC_BYTE1;
      7'h02: byte_at = `SYNC_BYTE2;
      default: byte_at = ram;
    endcase
  endfunction

  // Length check: odd last index inside the allowed span
  function automatic logic len_ok(input logic [6:0] n);
    len_ok = n[0] && (n >= `MIN_LAST_IDX) && (n <= `MAX_LAST_IDX);
  endfunction

  // ****************************************************************
  // Handshake and decode
  // ****************************************************************
  assign busy = pend_r || (state_r == ST_SEND);
  assign loadRdy = !busy;
  assign startTake = start && !busy;
  assign startOk = len_ok(lastIdx);
  assign frameGo = tick && (state_r == ST_IDLE) && pend_r && !txBit_r;
  assign byteEnd = tick && (state_r == ST_SEND) && (bitIdx_r == 3'h0);
  assign nextByte = byte_at(7'(byteIdx_r + 7'h01), rdData);
  // First sync byte, held in a net so that its bits can be selected
  assign firstByte = byte_at(7'h00, rdData);
  // Buffer is read one byte ahead so the data waits in its register
  assign rdAddr = 7'(byteIdx_r - 7'h02);

  // Writes are dropped while a message is queued or in flight
  always_comb begin
    wrGated = loadReq;
    wrGated.en = loadReq.en && !busy;
  end

  payload_byte_ram #(
    .DEPTH(`PAYLOAD_DEPTH),
    .AW(7)
  ) u_ram (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .wrReq(wrGated),
    .rdAddr(rdAddr),
    .rdData_r(rdData)
  );

  // ****************************************************************
  // Bit timing
  // ****************************************************************
  // Bit period counter; tick marks each bit boundary
  always_ff @(posedge clk_sys) begin
    if (!nrst || tick) begin
      bitCnt_r <= 32'h0000_0000;
    end else begin
      bitCnt_r <= bitCnt_r + 32'h0000_0001;
    end
  end
  assign tick = (bitCnt_r == 32'(BIT_CYCLES - 1));

  // ****************************************************************
  // Request capture
  // ****************************************************************
  // Valid starts queue a message; bad lengths pulse a reject
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      pend_r <= 1'b0;
      lastIdx_r <= 7'h00;
      rejectPulse_r <= 1'b0;
    end else begin
      rejectPulse_r <= startTake && !startOk;
      if (startTake && startOk) begin
        pend_r <= 1'b1;
        lastIdx_r <= lastIdx;
      end else if (frameGo) begin
        pend_r <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // Serialiser
  // ****************************************************************
  // Idle toggling, frame entry on a zero, back-to-back bytes MSB first
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      state_r <= ST_IDLE;
      txBit_r <= 1'b1;
      shift_r <= 8'h00;
      bitIdx_r <= 3'h0;
      byteIdx_r <= 7'h00;
      donePulse_r <= 1'b0;
    end else begin
      donePulse_r <= 1'b0;
      if (tick) begin
        unique case (state_r)
          ST_IDLE: begin
            if (frameGo) begin
              state_r <= ST_SEND;
              txBit_r <= firstByte[7];
              shift_r <= {firstByte[6:0], 1'b0};
              bitIdx_r <= 3'h1;
              byteIdx_r <= 7'h00;
            end else begin
              txBit_r <= !txBit_r;
            end
          end
          ST_SEND: begin
            if (bitIdx_r != 3'h0) begin
              txBit_r <= shift_r[7];
              shift_r <= {shift_r[6:0], 1'b0};
              bitIdx_r <= 3'(bitIdx_r + 3'h1);
            end else if (byteIdx_r == lastIdx_r) begin
              state_r <= ST_IDLE;
              txBit_r <= 1'b1;
              donePulse_r <= 1'b1;
            end else begin
              byteIdx_r <= 7'(byteIdx_r + 7'h01);
              txBit_r <= nextByte[7];
              shift_r <= {nextByte[6:0], 1'b0};
              bitIdx_r <= 3'h1;
            end
          end
        endcase
      end
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  property p_idleToggle;
    @(posedge clk_sys) disable iff (!nrst)
    (tick && state_r == ST_IDLE && !frameGo) |=> (txBit_r != $past(txBit_r));
  endproperty
  a_idleToggle: assert property (p_idleToggle) else $error("idle bit did not toggle");

  property p_idleEndsZero;
    @(posedge clk_sys) disable iff (!nrst)
    $rose(state_r == ST_SEND) |-> ($past(txBit_r) == 1'b0);
  endproperty
  a_idleEndsZero: assert property (p_idleEndsZero) else $error("frame began after a one");

  property p_queuedFirst;
    @(posedge clk_sys) disable iff (!nrst)
    $rose(state_r == ST_SEND) |-> $past(pend_r);
  endproperty
  a_queuedFirst: assert property (p_queuedFirst) else $error("frame without request");

  property p_syncFirstBits;
    @(posedge clk_sys) disable iff (!nrst)
    $rose(state_r == ST_SEND) |-> txBit_r ##1 (!tick)[*1] ##0 (shift_r == 8'h54);
  endproperty
  a_syncFirstBits: assert property (p_syncFirstBits) else $error("sync byte wrong");

  property p_idleRestartsOne;
    @(posedge clk_sys) disable iff (!nrst)
    $fell(state_r == ST_SEND) |-> (txBit_r && donePulse_r);
  endproperty
  a_idleRestartsOne: assert property (p_idleRestartsOne) else $error("idle restart not one");

  property p_lengthBound;
    @(posedge clk_sys) disable iff (!nrst)
    (state_r == ST_SEND) |-> (byteIdx_r <= lastIdx_r && lastIdx_r[0] && lastIdx_r >= `MIN_LAST_IDX);
  endproperty
  a_lengthBound: assert property (p_lengthBound) else $error("length out of bounds");

  property p_rejectBad;
    @(posedge clk_sys) disable iff (!nrst)
    (startTake && !lastIdx[0]) |=> (rejectPulse_r && !pend_r);
  endproperty
  a_rejectBad: assert property (p_rejectBad) else $error("even last index accepted");

  property p_backToBack;
    @(posedge clk_sys) disable iff (!nrst)
    (byteEnd && byteIdx_r != lastIdx_r) |=> (state_r == ST_SEND && bitIdx_r == 3'h1);
  endproperty
  a_backToBack: assert property (p_backToBack) else $error("gap between bytes");

  property p_msbFirst;
    @(posedge clk_sys) disable iff (!nrst)
    (tick && state_r == ST_SEND && bitIdx_r != 3'h0) |=> (txBit_r == $past(shift_r[7]));
  endproperty
  a_msbFirst: assert property (p_msbFirst) else $error("bit order wrong");

  c_frameDone: cover property (@(posedge clk_sys) disable iff (!nrst) donePulse_r);
  c_reject: cover property (@(posedge clk_sys) disable iff (!nrst) rejectPulse_r);
  c_byteStep: cover property (@(posedge clk_sys) disable iff (!nrst)
    byteEnd && byteIdx_r == 7'h03);

endmodule

/* cmd_frame_consts.svh */
/*
 * Constants of the payload command frame sender: sync bytes, frame size
 * limits and bit timing. Assumes inclusion by bare name from design files.
 */
// How it works
// - An idle pattern always precedes each command message on the link.
// - A message holds at most 128 eight-bit bytes, sync bytes included.
// - Bytes zero to two carry sync hex AA, A3, 12 in order.
// - Command bytes run from three to N; N odd, 5 to 127.
// - Idle is alternating ones and zeros at the command bit rate.
// - Idle ends on a zero before data; restarts with a one after.
// - Bytes of one message follow back to back, no idle between.
// - Data goes most significant bit and syllable first.
`ifndef CMD_FRAME_CONSTS_SVH
`define CMD_FRAME_CONSTS_SVH

// ****************************************************************
// Frame layout
// ****************************************************************
`define SYNC_BYTE0 8'hAA
`define SYNC_BYTE1 8'hA3
`define SYNC_BYTE2 8'h12
`define SYNC_LEN 7'h03
`define MAX_BYTES 8'h80
`define MIN_LAST_IDX 7'h05
`define MAX_LAST_IDX 7'h7F
`define PAYLOAD_DEPTH 128

// ****************************************************************
// Timing
// ****************************************************************
`define CLK_FREQ_HZ 250000000
`define BIT_RATE_BPS 2000
`define BIT_CYCLES_DFLT (`CLK_FREQ_HZ / `BIT_RATE_BPS)

`endif

/* cmd_frame_pkg.sv */
/*
 * Types shared by the frame sender and its payload buffer.
 * Assumes no other package.
 */
package cmd_frame_pkg;

  // Sender states
  typedef enum logic [0:0] {
    ST_IDLE = 1'b0,
    ST_SEND = 1'b1
  } tx_state_t;

  // One payload byte write into the buffer
  typedef struct packed {
    logic en;
    logic [6:0] addr;
    logic [7:0] data;
  } byte_wr_t;

endpackage

/* payload_byte_ram.sv */
/*
 * Payload byte buffer: one write port, one read port with registered data.
 * Assumes a single clock and a synchronous active-low reset.
 */
`timescale 1ns/1ps
module payload_byte_ram
  import cmd_frame_pkg::*;
#(
  parameter int DEPTH = 128,
  parameter int AW = 7
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // Write side
  input wire byte_wr_t wrReq,
  // Read side
  input wire logic [AW-1:0] rdAddr,
  output logic [7:0] rdData_r
);

  logic [7:0] mem [DEPTH];

  // Storage write
  always_ff @(posedge clk_sys) begin
    if (wrReq.en) begin
      mem[wrReq.addr[AW-1:0]] <= wrReq.data;
    end
  end

  // Registered read
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      rdData_r <= 8'h00;
    end else begin
      rdData_r <= mem[rdAddr];
    end
  end

endmodule

/* payload_cmd_rx_model.sv */
/*
 * Payload command decoder model: samples the line mid-bit, hunts for sync.
 * Assumes the sender's bit grid starts at reset release.
 */
`timescale 1ns/1ps
module payload_cmd_rx_model #(
  parameter int BIT_CYCLES = 8
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // Command line in, recovered bits out
  input wire logic lineIn,
  output logic rxBit,
  output logic rxStb,
  output logic syncHit
);
  // ****************************************************************
  // Receiver
  // ****************************************************************
  int cnt;
  logic [23:0] win;

  // Mid-bit sampling keeps clear of the sender's bit edges
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      cnt <= 0;
      rxStb <= 1'b0;
      rxBit <= 1'b1;
      syncHit <= 1'b0;
      win <= 24'h000000;
    end else begin
      cnt <= (cnt == BIT_CYCLES - 1) ? 0 : cnt + 1;
      rxStb <= (cnt == BIT_CYCLES / 2);
      syncHit <= (cnt == BIT_CYCLES / 2) && ({win[22:0], lineIn} == 24'hAAA312);
      if (cnt == BIT_CYCLES / 2) begin
        rxBit <= lineIn;
        win <= {win[22:0], lineIn};
      end
    end
  end
endmodule

/* payload_command_frame_sender_tb_top.sv */
/*
 * Testbench of the payload command frame sender: random payloads, length
 * limits and refusals. Assumes the decoder model in its own file.
 */
`timescale 1ns/1ps
module payload_command_frame_sender_tb_top;
  import cmd_frame_pkg::*;
  // ****************************************************************
  // Bench
  // ****************************************************************
  localparam int BC = 8;
  logic clk_sys, nrst, start, loadRdy, busy, rejectPulse_r, donePulse_r, txBit_r;
  logic rxBit, rxStb, syncHit;
  logic [6:0] lastIdx;
  byte_wr_t loadReq;
  int num_errors = 0, tests_run = 0, rejects = 0, syncs = 0, seed = 32'haa03, n;
  logic [7:0] pay [128];
  logic [6:0] bad [4] = '{7'h00, 7'h03, 7'h04, 7'h06};
  logic rq [$];

  payload_command_frame_sender #(.BIT_CYCLES(BC)) dut_u (.clk_sys(clk_sys), .nrst(nrst),
    .loadReq(loadReq), .loadRdy(loadRdy), .start(start), .lastIdx(lastIdx), .busy(busy),
    .rejectPulse_r(rejectPulse_r), .donePulse_r(donePulse_r), .txBit_r(txBit_r));
  payload_cmd_rx_model #(.BIT_CYCLES(BC)) rx_u (.clk_sys(clk_sys), .nrst(nrst),
    .lineIn(txBit_r), .rxBit(rxBit), .rxStb(rxStb), .syncHit(syncHit));

  // Clock
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end

  // Bit log and pulse counts, taken away from the driving edge
  always @(negedge clk_sys) begin
    if (rxStb === 1'b1) rq.push_back(rxBit);
    if (rejectPulse_r === 1'b1) rejects++;
    if (syncHit === 1'b1) syncs++;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic end_of_test();
    $display("errors=%0d checks=%0d", num_errors, tests_run);
    if (num_errors == 0 && tests_run > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // Load N-2 bytes, send, optionally poke while busy, then check the line
  task automatic send(input int n, input bit poke);
    int k, st, f0;
    logic [7:0] b;
    for (k = 0; k <= n - 3; k++) begin
      pay[k] = 8'($random(seed));
      @(posedge clk_sys);
      loadReq <= '{en: 1'b1, addr: k[6:0], data: pay[k]};
    end
    @(posedge clk_sys);
    loadReq.en <= 1'b0;
    start <= 1'b1;
    lastIdx <= n[6:0];
    st = rq.size();
    @(posedge clk_sys);
    start <= 1'b0;
    @(negedge clk_sys);
    chk({busy, loadRdy}, 2'b10);
    if (poke) begin
      @(posedge clk_sys);
      loadReq <= '{en: 1'b1, addr: 7'h00, data: ~pay[0]};
      start <= 1'b1;
      lastIdx <= 7'h04;
      @(posedge clk_sys);
      loadReq.en <= 1'b0;
      start <= 1'b0;
    end
    for (k = 0; k < 12000 && donePulse_r !== 1'b1; k++) @(negedge clk_sys);
    chk({k < 12000, busy}, 2'b10);
    repeat (BC + 2) @(negedge clk_sys);
    f0 = rq.size() - 1 - (n + 1) * 8;
    chk({rq[$], rq[f0 - 1]}, 2'b10);
    chk(f0 - st <= 2, 1'b1);
    for (k = (st > 0) ? st : 1; k < f0; k++) chk(rq[k] ^ rq[k - 1], 1'b1);
    for (k = 0; k < (n + 1) * 8; k++) begin
      b = (k < 8) ? 8'hAA : (k < 16) ? 8'hA3 : (k < 24) ? 8'h12 : pay[k / 8 - 3];
      chk(rq[f0 + k], b[7 - k % 8]);
    end
  endtask

  // Watchdog
  initial begin
    repeat (40000) @(posedge clk_sys);
    num_errors++;
    end_of_test();
  end

  // Main sequence
  initial begin
    nrst = 1'b0;
    start = 1'b0;
    lastIdx = 7'h00;
    loadReq = '0;
    repeat (5) @(posedge clk_sys);
    nrst <= 1'b1;
    @(negedge clk_sys);
    chk({txBit_r, busy, loadRdy, donePulse_r, rejectPulse_r}, 5'b10100);
    send(5, 1'b0);
    send(127, 1'b1);
    n = 5 + 2 * ({$random(seed)} % 61);
    send(n, 1'b0);
    chk(rejects, 0);
    chk(syncs, 3);
    foreach (bad[i]) begin
      @(posedge clk_sys);
      start <= 1'b1;
      lastIdx <= bad[i];
      @(posedge clk_sys);
      start <= 1'b0;
      @(negedge clk_sys);
      chk({rejectPulse_r, busy}, 2'b10);
      @(negedge clk_sys);
      chk(rejectPulse_r, 1'b0);
    end
    chk(rejects, 4);
    send(5, 1'b0);
    chk(syncs, 4);
    end_of_test();
  end
endmodule
